// ---- rtl/nfc_host.sv ----
// Host sequencer for NAND block erase, reset and feature commands with a Wishbone slave
//
// The Wishbone slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module nfc_host
  import nfc_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input  wire logic              clk_sys,
  input  wire logic              srst,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o,
  output logic                   nand_ce_n,
  output logic                   nand_cle,
  output logic                   nand_ale,
  output logic                   nand_we_n,
  output logic                   nand_re_n,
  output logic                   write_protect_n,
  output logic [7:0]             nand_io_out,
  output logic                   nand_io_oe_n,
  input  wire logic [7:0]        nand_io_in,
  input  wire logic              ready_busy_n
);
  import nfc_pkg::*;

  // Only the low byte of the address is decoded
  if (ADDR_W < 8) begin : g_bad_addr_w
    $error("nfc_host: ADDR_W must be at least 8");
  end

  typedef enum logic [2:0] {S_IDLE, S_STEP, S_CYC, S_SETUP, S_BUSY, S_NEXT} nfc_state_t;

  function automatic nfc_step_t mk(input nfc_kind_t k, input logic [7:0] d, input nfc_dest_t ds,
                                   input logic [1:0] bs, input logic w, input logic l);
    nfc_step_t s;
    s = '{kind: k, data: d, dest: ds, byte_sel: bs, wait_busy: w, last: l};
    return s;
  endfunction

  function automatic logic [31:0] merge_sel(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Step list of each operation, one pin cycle per step
  function automatic nfc_step_t step_of(input logic [2:0] op, input logic [3:0] idx,
                                        input logic [ROW_W-1:0] row, input logic [7:0] fa,
                                        input logic [31:0] prm);
    nfc_step_t s;
    s = mk(K_CMD, CMD_STATUS, D_STAT, 2'd0, 1'b0, 1'b0);
    case (op)
      OP_ERASE, OP_QUEUE, OP_ENH: begin
        case (idx)
          4'd0: s = mk(K_CMD, (op == OP_ENH) ? CMD_STATUS_ENH : CMD_ERASE_SETUP,
                       D_STAT, 2'd0, 1'b0, 1'b0);
          4'd1: s = mk(K_ADDR, row[7:0], D_STAT, 2'd0, 1'b0, 1'b0);
          4'd2: s = mk(K_ADDR, row[15:8], D_STAT, 2'd0, 1'b0, 1'b0);
          4'd3: s = mk(K_ADDR, row[23:16], D_STAT, 2'd0, 1'b0, 1'b0);
          4'd4: begin
            if (op == OP_ENH) begin
              s = mk(K_RDATA, 8'h00, D_ENH, 2'd0, 1'b0, 1'b1);
            end else begin
              s = mk(K_CMD, (op == OP_QUEUE) ? CMD_ERASE_QUEUE : CMD_ERASE_GO,
                     D_STAT, 2'd0, 1'b1, 1'b0);
            end
          end
          4'd5: s = mk(K_CMD, CMD_STATUS, D_STAT, 2'd0, 1'b0, 1'b0);
          default: s = mk(K_RDATA, 8'h00, D_STAT, 2'd0, 1'b0, 1'b1);
        endcase
      end
      OP_RESET: begin
        case (idx)
          4'd0: s = mk(K_CMD, CMD_RESET, D_STAT, 2'd0, 1'b1, 1'b0);
          4'd1: s = mk(K_CMD, CMD_STATUS, D_STAT, 2'd0, 1'b0, 1'b0);
          default: s = mk(K_RDATA, 8'h00, D_STAT, 2'd0, 1'b0, 1'b1);
        endcase
      end
      OP_SETF: begin
        case (idx)
          4'd0: s = mk(K_CMD, CMD_SET_FEAT, D_STAT, 2'd0, 1'b0, 1'b0);
          4'd1: s = mk(K_ADDR, fa, D_STAT, 2'd0, 1'b0, 1'b0);
          4'd2: s = mk(K_WDATA, prm[7:0], D_STAT, 2'd0, 1'b0, 1'b0);
          4'd3: s = mk(K_WDATA, prm[15:8], D_STAT, 2'd0, 1'b0, 1'b0);
          4'd4: s = mk(K_WDATA, prm[23:16], D_STAT, 2'd0, 1'b0, 1'b0);
          default: s = mk(K_WDATA, prm[31:24], D_STAT, 2'd0, 1'b1, 1'b1);
        endcase
      end
      OP_GETF: begin
        case (idx)
          4'd0: s = mk(K_CMD, CMD_GET_FEAT, D_STAT, 2'd0, 1'b0, 1'b0);
          4'd1: s = mk(K_ADDR, fa, D_STAT, 2'd0, 1'b1, 1'b0);
          4'd2: s = mk(K_RDATA, 8'h00, D_PARAM, 2'd0, 1'b0, 1'b0);
          4'd3: s = mk(K_RDATA, 8'h00, D_PARAM, 2'd1, 1'b0, 1'b0);
          4'd4: s = mk(K_RDATA, 8'h00, D_PARAM, 2'd2, 1'b0, 1'b0);
          default: s = mk(K_RDATA, 8'h00, D_PARAM, 2'd3, 1'b0, 1'b1);
        endcase
      end
      default: begin
        case (idx)
          4'd0: s = mk(K_CMD, CMD_STATUS, D_STAT, 2'd0, 1'b0, 1'b0);
          default: s = mk(K_RDATA, 8'h00, D_STAT, 2'd0, 1'b0, 1'b1);
        endcase
      end
    endcase
    return s;
  endfunction

  nfc_state_t     state;
  logic [2:0]     op;
  logic [3:0]     idx;
  logic [7:0]     wait_cnt;
  logic [ROW_W-1:0] row;
  logic [ROW_W-1:0] op_row;
  logic [7:0]     faddr;
  logic [31:0]    param;
  logic [7:0]     status;
  logic [7:0]     enh_status;
  logic           done;
  logic           refused;
  logic           plane_pending;
  logic           two_plane_op;
  logic           wp_level;
  logic           cyc_start;
  nfc_pins_t      cyc_pins;
  logic           cyc_done;
  logic [7:0]     cyc_rd;

  // Bus decode
  wire logic       bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic       bus_wr    = bus_req && wb_we_i;
  wire logic [7:0] bus_off   = wb_adr_i[7:0];
  wire logic       hit_ctrl  = bus_wr && (bus_off == REG_CTRL) && wb_sel_i[0];
  wire logic [2:0] req_op    = wb_dat_i[2:0];
  wire logic       busy      = (state != S_IDLE);
  // Set and get feature operations are refused while a plane is queued
  wire logic       op_legal  = !plane_pending || (req_op == OP_ERASE) || (req_op == OP_QUEUE)
                               || (req_op == OP_RESET) || (req_op == OP_STAT)
                               || (req_op == OP_ENH);
  wire logic       go        = hit_ctrl && !busy && (req_op != 3'h0) && op_legal;
  wire logic       reject    = hit_ctrl && (busy || !op_legal);
  wire nfc_step_t  cur       = step_of(op, idx, op_row, faddr, param);
  wire logic       wait_done = (wait_cnt == 8'h00);
  // Completion of an erase that covered two planes with a fail shows needs per-plane status
  wire logic       need_enh  = (op == OP_ERASE) && two_plane_op && cyc_rd[SR_FAIL];
  wire logic [ROW_W-1:0] plane_row = (req_op == OP_QUEUE)
                               ? (row & ~(ROW_W'(1) << ROW_PLANE_BIT))
                               : ((req_op == OP_ERASE) && plane_pending)
                                 ? (row | (ROW_W'(1) << ROW_PLANE_BIT)) : row;
  wire logic [31:0] rd_mux   = (bus_off == REG_CTRL)   ? {29'h0, op} :
                               (bus_off == REG_ROW)    ? {8'h00, row} :
                               (bus_off == REG_FADDR)  ? {24'h0, faddr} :
                               (bus_off == REG_PARAM)  ? param :
                               (bus_off == REG_STATUS) ? {8'h00, enh_status, status, 4'h0,
                                                          plane_pending, refused, done, busy} :
                               (bus_off == REG_WP)     ? {31'h0, wp_level} : 32'h0;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      row      <= '0;
      faddr    <= 8'h00;
      wp_level <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_mux : 32'h0;
      if (bus_wr && (bus_off == REG_ROW)) begin
        row <= ROW_W'(merge_sel({8'h00, row}, wb_dat_i, wb_sel_i));
      end
      if (bus_wr && (bus_off == REG_FADDR) && wb_sel_i[0]) begin
        faddr <= wb_dat_i[7:0];
      end
      if (bus_wr && (bus_off == REG_WP) && wb_sel_i[0]) begin
        wp_level <= wb_dat_i[0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state         <= S_IDLE;
      op            <= 3'h0;
      idx           <= 4'h0;
      wait_cnt      <= 8'h00;
      op_row        <= '0;
      param         <= PARAM_RST;
      status        <= STATUS_RST;
      enh_status    <= STATUS_RST;
      done          <= 1'b0;
      refused       <= 1'b0;
      plane_pending <= 1'b0;
      two_plane_op  <= 1'b0;
      cyc_start     <= 1'b0;
      nand_ce_n     <= 1'b1;
    end else begin
      cyc_start <= 1'b0;
      if (reject) begin
        refused <= 1'b1;
      end else if (go) begin
        refused <= 1'b0;
      end
      if (bus_wr && (bus_off == REG_PARAM) && !busy) begin
        param <= merge_sel(param, wb_dat_i, wb_sel_i);
      end
      case (state)
        S_IDLE: begin
          nand_ce_n <= 1'b1;
          if (go) begin
            state        <= S_STEP;
            op           <= req_op;
            idx          <= 4'h0;
            op_row       <= plane_row;
            done         <= 1'b0;
            nand_ce_n    <= 1'b0;
            two_plane_op <= (req_op == OP_ERASE) && plane_pending;
          end
        end
        S_STEP: begin
          cyc_start <= 1'b1;
          state     <= S_CYC;
        end
        S_CYC: begin
          if (cyc_done) begin
            if (cur.kind == K_RDATA) begin
              if (cur.dest == D_PARAM) begin
                param[8*cur.byte_sel +: 8] <= cyc_rd;
              end else if (cur.dest == D_ENH) begin
                enh_status <= cyc_rd;
              end else begin
                status <= cyc_rd;
              end
            end
            wait_cnt <= 8'(BUSY_SETUP_CYC);
            state    <= cur.wait_busy ? S_SETUP : S_NEXT;
          end
        end
        S_SETUP: begin
          wait_cnt <= wait_cnt - 8'h01;
          if (wait_done) begin
            state <= S_BUSY;
          end
        end
        S_BUSY: begin
          if (ready_busy_n) begin
            state <= S_NEXT;
          end
        end
        default: begin
          if (!cur.last) begin
            idx   <= idx + 4'h1;
            state <= S_STEP;
          end else if (need_enh) begin
            // The final erase has consumed the queued plane
            plane_pending <= 1'b0;
            op    <= OP_ENH;
            idx   <= 4'h0;
            state <= S_STEP;
          end else begin
            state <= S_IDLE;
            done  <= 1'b1;
            if (op == OP_QUEUE) begin
              // Next queue or final erase only once both ready bits are set
              plane_pending <= status[SR_RDY] && status[SR_ARRAY_RDY];
            end else if ((op == OP_ERASE) || (op == OP_RESET)) begin
              plane_pending <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  nfc_pin_cycle u_cycle (
    .clk_sys (clk_sys),
    .srst    (srst),
    .start   (cyc_start),
    .kind    (cur.kind),
    .data    (cur.data),
    .io_in   (nand_io_in),
    .pins    (cyc_pins),
    .done    (cyc_done),
    .rd_byte (cyc_rd)
  );

  assign nand_cle        = cyc_pins.cle;
  assign nand_ale        = cyc_pins.ale;
  assign nand_we_n       = cyc_pins.we_n;
  assign nand_re_n       = cyc_pins.re_n;
  assign nand_io_out     = cyc_pins.io_out;
  assign nand_io_oe_n    = cyc_pins.io_oe_n;
  assign write_protect_n = wp_level;
endmodule // nfc_host

// ---- rtl/nfc_pin_cycle.sv ----
// One latch or read strobe cycle on the NAND pins
`timescale 1ns/1ps
module nfc_pin_cycle
  import nfc_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             srst,
  input  wire logic             start,
  input  wire nfc_pkg::nfc_kind_t kind,
  input  wire logic [7:0]       data,
  input  wire logic [7:0]       io_in,
  output nfc_pkg::nfc_pins_t    pins,
  output logic                  done,
  output logic [7:0]            rd_byte
);
  import nfc_pkg::*;

  typedef enum logic [1:0] {C_IDLE, C_LOW, C_HIGH} nfc_cyc_t;

  nfc_cyc_t   state;
  logic [3:0] cnt;
  logic       is_read;

  wire logic [3:0] low_len  = (kind == K_RDATA) ? 4'(RE_LOW_CYC) : 4'(WE_LOW_CYC);
  wire logic       low_end  = (state == C_LOW) && (cnt == 4'h0);
  wire logic       high_end = (state == C_HIGH) && (cnt == 4'h0);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state   <= C_IDLE;
      cnt     <= 4'h0;
      is_read <= 1'b0;
      pins    <= '{cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1, io_out: 8'h00, io_oe_n: 1'b1};
      done    <= 1'b0;
      rd_byte <= 8'h00;
    end else begin
      done <= 1'b0;
      case (state)
        C_IDLE: begin
          if (start) begin
            state        <= C_LOW;
            cnt          <= low_len - 4'h1;
            is_read      <= (kind == K_RDATA);
            pins.cle     <= (kind == K_CMD);
            pins.ale     <= (kind == K_ADDR);
            pins.io_out  <= data;
            pins.io_oe_n <= (kind == K_RDATA);
            pins.we_n    <= (kind == K_RDATA);
            pins.re_n    <= (kind != K_RDATA);
          end
        end
        C_LOW: begin
          cnt <= cnt - 4'h1;
          if (low_end) begin
            // Data is latched by the device on the rising write strobe
            state     <= C_HIGH;
            cnt       <= 4'(WE_HIGH_CYC) - 4'h1;
            pins.we_n <= 1'b1;
            pins.re_n <= 1'b1;
            if (is_read) begin
              rd_byte <= io_in;
            end
          end
        end
        default: begin
          cnt <= cnt - 4'h1;
          if (high_end) begin
            state        <= C_IDLE;
            done         <= 1'b1;
            pins.cle     <= 1'b0;
            pins.ale     <= 1'b0;
            pins.io_oe_n <= 1'b1;
          end
        end
      endcase
    end
  end
endmodule // nfc_pin_cycle

// ---- rtl/nfc_pkg.sv ----
// Shared constants and types of the NAND erase, reset and feature sequencer host
package nfc_pkg;
  // Clock and pin timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int WE_LOW_NS     = 20;
  localparam int WE_HIGH_NS    = 20;
  localparam int RE_LOW_NS     = 30;
  localparam int BUSY_SETUP_NS = 100;
  localparam int WE_LOW_CYC    = (WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WE_HIGH_CYC   = (WE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RE_LOW_CYC    = (RE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_SETUP_CYC = (BUSY_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Wishbone register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ROW    = 8'h04;
  localparam logic [7:0] REG_FADDR  = 8'h08;
  localparam logic [7:0] REG_PARAM  = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_WP     = 8'h14;

  // Operation codes written to the control register
  localparam logic [2:0] OP_ERASE  = 3'h1;
  localparam logic [2:0] OP_QUEUE  = 3'h2;
  localparam logic [2:0] OP_RESET  = 3'h3;
  localparam logic [2:0] OP_SETF   = 3'h4;
  localparam logic [2:0] OP_GETF   = 3'h5;
  localparam logic [2:0] OP_STAT   = 3'h6;
  localparam logic [2:0] OP_ENH    = 3'h7;

  // Device command bytes
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO    = 8'hD0;
  localparam logic [7:0] CMD_ERASE_QUEUE = 8'hD1;
  localparam logic [7:0] CMD_STATUS      = 8'h70;
  localparam logic [7:0] CMD_STATUS_ENH  = 8'h78;
  localparam logic [7:0] CMD_RESET       = 8'hFF;
  localparam logic [7:0] CMD_GET_FEAT    = 8'hEE;
  localparam logic [7:0] CMD_SET_FEAT    = 8'hEF;

  // Row address layout and status bits
  localparam int ROW_W          = 24;
  localparam int ROW_PLANE_BIT  = 6;
  localparam int SR_FAIL        = 0;
  localparam int SR_ARRAY_RDY   = 5;
  localparam int SR_RDY         = 6;

  // Reset values
  localparam logic [7:0]  STATUS_RST = 8'h00;
  localparam logic [31:0] PARAM_RST  = 32'h0000_0000;

  typedef enum logic [1:0] {K_CMD, K_ADDR, K_WDATA, K_RDATA} nfc_kind_t;
  typedef enum logic [1:0] {D_STAT, D_PARAM, D_ENH} nfc_dest_t;

  typedef struct packed {
    nfc_kind_t  kind;
    logic [7:0] data;
    nfc_dest_t  dest;
    logic [1:0] byte_sel;
    logic       wait_busy;
    logic       last;
  } nfc_step_t;

  typedef struct packed {
    logic       cle;
    logic       ale;
    logic       we_n;
    logic       re_n;
    logic [7:0] io_out;
    logic       io_oe_n;
  } nfc_pins_t;
endpackage : nfc_pkg

// ---- verification/nfc_dev_model.sv ----
// Behavioural NAND device answering the host sequencer
`timescale 1ns/1ps
module nfc_dev_model #(
  parameter int T_ERS = 120,
  parameter int T_SHORT = 25
) (
  input  wire logic       clk_sys,
  input  wire logic       ce_n,
  input  wire logic       cle,
  input  wire logic       ale,
  input  wire logic       we_n,
  input  wire logic       re_n,
  input  wire logic       wp_n,
  input  wire logic [7:0] din,
  input  wire logic       fail,
  output logic      [7:0] dout,
  output logic            rb_n
);
  logic [7:0] cmd, fa, st, pend, last, rd [4], feat [2][4], log_q [$];
  int         nd, ri, busy;
  initial begin
    st = 8'hE0;
    last = 8'h00;
    rb_n = 1'b1;
    busy = 0;
    feat = '{default: 8'h00};
  end
  // Released bus shows the inverse of the last byte
  assign dout = (!ce_n && !re_n) ? ((cmd == 8'hEE) ? rd[ri] : st) : ~last;
  task automatic go(input logic [7:0] f, input int t);
    st = {wp_n, 7'h00};
    pend = {wp_n, 7'h60} | f;
    busy = t;
  endtask
  always @(posedge re_n) if (!ce_n) begin
    last = (cmd == 8'hEE) ? rd[ri] : st;
    ri = (ri + 1) % 4;
  end
  always @(posedge we_n) if (!ce_n) begin
    if (cle) begin
      log_q.push_back(din);
      cmd = din;
      nd = 0;
      ri = 0;
      if (din == 8'hD0) go(fail ? 8'h01 : 8'h00, T_ERS);
      if (din == 8'hD1) go(8'h00, T_SHORT);
      if (din == 8'hFF) go(8'h00, T_SHORT);
    end else if (ale) begin
      log_q.push_back(din);
      fa = din;
      if (cmd == 8'hEE) begin
        rd = '{default: 8'h00};
        if (fa[7:1] == 7'h40) rd = feat[fa[0]];
        go(8'h00, T_SHORT);
      end
    end else if (cmd == 8'hEF) begin
      if (fa[7:1] == 7'h40) feat[fa[0]][nd] = din;
      nd++;
      if (nd == 4) go(8'h00, T_SHORT);
    end
  end
  always @(posedge clk_sys) begin
    rb_n <= (busy == 0);
    if (busy != 0) begin
      busy--;
      if (busy == 0) st = pend;
    end
  end
endmodule // nfc_dev_model

// ---- verification/nfc_host_props.sv ----
// Checker of the NAND host pin timing
`timescale 1ns/1ps
module nfc_host_props (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic nand_ce_n,
  input wire logic nand_cle,
  input wire logic nand_ale,
  input wire logic nand_we_n,
  input wire logic nand_re_n,
  input wire logic nand_io_oe_n,
  input wire logic write_protect_n,
  input wire logic ready_busy_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  property p_we_len; $fell(nand_we_n) |-> !nand_we_n[*2] ##1 nand_we_n[*2]; endproperty
  a_we_len: assert property (p_we_len) else $error("write strobe width");
  property p_re_len; $fell(nand_re_n) |-> !nand_re_n[*3] ##1 nand_re_n[*2]; endproperty
  a_re_len: assert property (p_re_len) else $error("read strobe width");
  property p_rb_quiet; ($fell(nand_we_n) || $fell(nand_re_n)) |-> ready_busy_n; endproperty
  a_rb_quiet: assert property (p_rb_quiet) else $error("strobe while busy");
  property p_one_latch; !(nand_cle && nand_ale); endproperty
  a_one_latch: assert property (p_one_latch) else $error("both latches high");
  property p_rd_float; !nand_re_n |-> nand_io_oe_n; endproperty
  a_rd_float: assert property (p_rd_float) else $error("host drives during read");
  property p_ce_hold; ($fell(nand_we_n) || $fell(nand_re_n)) |-> !nand_ce_n; endproperty
  a_ce_hold: assert property (p_ce_hold) else $error("strobe without select");
  property p_wp_fix; !nand_ce_n && $past(!nand_ce_n) |-> $stable(write_protect_n); endproperty
  a_wp_fix: assert property (p_wp_fix) else $error("protect moved in op");
  property p_latch_we;
    $fell(nand_we_n) |=> ($stable(nand_cle) && $stable(nand_ale) && $stable(nand_io_oe_n))[*3];
  endproperty
  a_latch_we: assert property (p_latch_we) else $error("latch moved in strobe");
  c_ale: cover property (nand_ale && $rose(nand_we_n));
  c_read: cover property ($rose(nand_re_n));
  c_busy: cover property ($fell(ready_busy_n));
endmodule // nfc_host_props

bind nfc_host nfc_host_props u_props (.clk_sys, .srst, .nand_ce_n, .nand_cle, .nand_ale,
  .nand_we_n, .nand_re_n, .nand_io_oe_n, .write_protect_n, .ready_busy_n);

// ---- verification/nfc_host_tb.sv ----
// Self-checking bench of the NAND erase, reset and feature host
`timescale 1ns/1ps
module nfc_host_tb;
  import nfc_pkg::*;
  logic        clk_sys, srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, nand_ce_n, nand_cle;
  logic        nand_ale, nand_we_n, nand_re_n, write_protect_n, nand_io_oe_n, ready_busy_n;
  logic        fail;
  logic [3:0]  wb_sel_i;
  logic [7:0]  wb_adr_i, nand_io_out, nand_io_in, dev_io;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  int          bad_count, n_compared;
  assign nand_io_in = nand_io_oe_n ? dev_io : nand_io_out;
  nfc_host uut (.clk_sys, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .nand_ce_n, .nand_cle, .nand_ale, .nand_we_n,
    .nand_re_n, .write_protect_n, .nand_io_out, .nand_io_oe_n, .nand_io_in, .ready_busy_n);
  nfc_dev_model dev (.clk_sys, .ce_n(nand_ce_n), .cle(nand_cle), .ale(nand_ale),
    .we_n(nand_we_n), .re_n(nand_re_n), .wp_n(write_protect_n), .din(nand_io_in),
    .fail(fail), .dout(dev_io), .rb_n(ready_busy_n));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic end_sim;
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      bad_count++;
      end_sim;
    end
  endtask
  task automatic start(input logic [2:0] c);
    dev.log_q.delete();
    wb(1'b1, REG_CTRL, {29'h0, c});
  endtask
  task automatic idle;
    int n;
    n = 0;
    do begin
      wb(1'b0, REG_STATUS, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 500);
    if (q[0] !== 1'b0) begin
      bad_count++;
      end_sim;
    end
  endtask
  task automatic op(input logic [2:0] c);
    start(c);
    idle;
  endtask
  task automatic chk_log(input logic [7:0] e [$]);
    chk(dev.log_q.size(), e.size());
    foreach (e[i]) chk(dev.log_q[i], e[i]);
  endtask
  task automatic setf(input logic [7:0] fa, input logic [31:0] v);
    wb(1'b1, REG_FADDR, {24'h0, fa});
    wb(1'b1, REG_PARAM, v);
    op(OP_SETF);
    chk_log('{CMD_SET_FEAT, fa});
  endtask
  task automatic getf(input logic [7:0] fa, input logic [31:0] e);
    wb(1'b1, REG_FADDR, {24'h0, fa});
    wb(1'b1, REG_PARAM, 32'hA5A5_A5A5);
    op(OP_GETF);
    chk_log('{CMD_GET_FEAT, fa});
    wb(1'b0, REG_PARAM, 32'h0);
    chk(q, e);
  endtask
  task automatic t_regs;
    wb(1'b0, REG_STATUS, 32'h0);
    chk(q, {16'h0, STATUS_RST, 8'h00});
    wb(1'b0, REG_PARAM, 32'h0);
    chk(q, PARAM_RST);
    wb(1'b1, 8'h40, 32'hFFFF_FFFF);
    wb(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, REG_CTRL, 32'h0);
    wb(1'b0, REG_STATUS, 32'h0);
    chk(q, 32'h0);
  endtask
  task automatic t_erase;
    wb(1'b1, REG_WP, 32'h1);
    wb(1'b1, REG_ROW, 32'h0001_2305);
    op(OP_ERASE);
    chk_log('{8'h60, 8'h05, 8'h23, 8'h01, 8'hD0, 8'h70});
    wb(1'b0, REG_STATUS, 32'h0);
    chk(q[15:0], 16'hE002);
  endtask
  task automatic t_two_plane;
    wb(1'b1, REG_ROW, 32'h0000_0A47);
    op(OP_QUEUE);
    chk_log('{8'h60, 8'h07, 8'h0A, 8'h00, 8'hD1, 8'h70});
    wb(1'b0, REG_STATUS, 32'h0);
    chk(q[3], 1'b1);
    wb(1'b1, REG_CTRL, {29'h0, OP_GETF});
    wb(1'b0, REG_STATUS, 32'h0);
    chk(q[3:0], 4'hE);
    fail <= 1'b1;
    wb(1'b1, REG_ROW, 32'h0000_0B45);
    op(OP_ERASE);
    chk_log('{8'h60, 8'h45, 8'h0B, 8'h00, 8'hD0, 8'h70, 8'h78, 8'h45, 8'h0B, 8'h00});
    wb(1'b0, REG_STATUS, 32'h0);
    chk(q[23:8], 16'hE1E1);
    chk(q[3], 1'b0);
    fail <= 1'b0;
  endtask
  task automatic t_reset;
    for (int w = 0; w < 2; w++) begin
      wb(1'b1, REG_WP, w);
      op(OP_RESET);
      chk_log('{CMD_RESET, CMD_STATUS});
      wb(1'b0, REG_STATUS, 32'h0);
      chk(q[15:8], w ? 8'hE0 : 8'h60);
    end
  endtask
  task automatic t_feat;
    for (int v = 0; v < 4; v++) begin
      setf(8'h80, v);
      getf(8'h80, v);
    end
    setf(8'h81, 32'h2);
    getf(8'h81, 32'h2);
    setf(8'h90, 32'h1);
    getf(8'h90, 32'h0);
    getf(8'h80, 32'h3);
    op(OP_RESET);
    getf(8'h81, 32'h2);
  endtask
  task automatic t_misc;
    op(OP_STAT);
    chk_log('{CMD_STATUS});
    op(OP_ENH);
    chk_log('{CMD_STATUS_ENH, 8'h45, 8'h0B, 8'h00});
    start(OP_ERASE);
    wb(1'b1, REG_CTRL, {29'h0, OP_STAT});
    wb(1'b1, REG_PARAM, 32'h0000_0055);
    wb(1'b0, REG_STATUS, 32'h0);
    chk(q[2:0], 3'b101);
    idle;
    wb(1'b0, REG_PARAM, 32'h0);
    chk(q, 32'h2);
  endtask
  initial begin
    srst = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    fail = 1'b0;
    bad_count = 0;
    n_compared = 0;
    repeat (8) @(posedge clk_sys);
    srst <= 1'b0;
    t_regs;
    t_erase;
    t_two_plane;
    t_reset;
    t_feat;
    t_misc;
    end_sim;
  end
endmodule // nfc_host_tb
